// ==== logic/sar_dev.sv ====
// converter end: conversion sequencing and serial readout
// assumes the host drives select and bit clock from mclk-timed logic
`timescale 1ns/1ps
module sar_dev #(
  parameter int unsigned POR_CYCLES = sar_pkg::POR_CYC
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // serial link
  sar_link_if.dev link,
  // analog side: code presented for sampling
  input wire sar_pkg::sar_code_t sample_code,
  // status
  output logic por_done,
  output logic primed,
  output logic dynamic_mode,
  // result of the last frame, unresolved bits zero
  output sar_pkg::sar_code_t result,
  output logic [3:0] result_bits,
  output logic result_stb
);
  import sar_pkg::*;

  logic sel_s1_q;
  logic sel_s2_q;
  logic sel_prev_q;
  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_prev_q;
  logic sel_fall;
  logic sel_rise;
  logic bit_fall;
  logic [POR_W-1:0] por_cnt_q;
  logic active_q;
  logic [EDGE_W-1:0] edge_cnt_q;
  logic [EDGE_W-1:0] nxt_edge;
  logic [3:0] bit_idx;
  logic fwd_bit;
  logic rev_bit;
  sar_code_t resolve_phase_q;
  sar_code_t res_q;
  logic [3:0] nbits_q;
  logic sdo_q;
  logic sdo_oe_n_q;

  // two-stage synchronisers for the link pins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
    end else if (ce) begin
      sel_s1_q <= link.select_shutdown_n;
      sel_s2_q <= sel_s1_q;
      clk_s1_q <= link.conversion_bit_clock;
      clk_s2_q <= clk_s1_q;
    end
  end

  // previous values for edge detection
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_prev_q <= 1'b1;
      clk_prev_q <= 1'b0;
    end else if (ce) begin
      sel_prev_q <= sel_s2_q;
      clk_prev_q <= clk_s2_q;
    end
  end

  // edge strobes, all from synchronised levels
  assign sel_fall = sel_prev_q & ~sel_s2_q;
  assign sel_rise = ~sel_prev_q & sel_s2_q;
  assign bit_fall = clk_prev_q & ~clk_s2_q;

  // power-on reset timer; nothing is accepted until it ends
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      por_cnt_q <= '0;
      por_done <= 1'b0;
    end else if (ce && !por_done) begin
      if (por_cnt_q == POR_W'(POR_CYCLES - 1)) begin
        por_done <= 1'b1;
      end else begin
        por_cnt_q <= por_cnt_q + POR_W'(1);
      end
    end
  end

  // frame state and falling edge counter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      active_q <= 1'b0;
      edge_cnt_q <= '0;
    end else if (ce) begin
      if (sel_s2_q) begin
        // abort at once, whatever the count
        active_q <= 1'b0;
        edge_cnt_q <= '0;
      end else if (sel_fall && por_done) begin
        // sampling phase opens at the select edge
        active_q <= 1'b1;
        edge_cnt_q <= '0;
      end else if (active_q && bit_fall && edge_cnt_q != FLOAT_EDGE) begin
        edge_cnt_q <= edge_cnt_q + EDGE_W'(1);
      end
    end
  end

  // number of the falling edge now arriving, and the bit it sends
  always_comb begin
    nxt_edge = edge_cnt_q + EDGE_W'(1);
    fwd_bit = (nxt_edge >= MSB_EDGE) && (nxt_edge <= LSB_EDGE);
    rev_bit = (nxt_edge > LSB_EDGE) && (nxt_edge <= REV_END_EDGE);
    if (fwd_bit) begin
      bit_idx = 4'(LSB_EDGE - nxt_edge);
    end else if (rev_bit) begin
      bit_idx = 4'(nxt_edge - LSB_EDGE);
    end else begin
      bit_idx = 4'h0;
    end
  end

  // hold the sampled code when the sampling phase closes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      resolve_phase_q <= CODE_MID;
    end else if (ce) begin
      if (active_q && bit_fall && nxt_edge == NULL_EDGE) begin
        resolve_phase_q <= sample_code;
      end
    end
  end

  // serial output: changes on a bit clock falling edge, and clears low when deselected
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end else if (ce) begin
      if (!active_q || sel_s2_q) begin
        // floating from select fall until the null bit
        sdo_oe_n_q <= 1'b1;
        sdo_q <= 1'b0;
      end else if (bit_fall && edge_cnt_q != FLOAT_EDGE) begin
        if (nxt_edge == NULL_EDGE) begin
          sdo_oe_n_q <= 1'b0;
          sdo_q <= 1'b0;
        end else if (fwd_bit || rev_bit) begin
          sdo_q <= resolve_phase_q[bit_idx];
        end else begin
          // repeat done: float until select goes high and low
          sdo_oe_n_q <= 1'b1;
          sdo_q <= 1'b0;
        end
      end
    end
  end

  // bits resolved so far; a short frame keeps only these
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      res_q <= CODE_MID;
      nbits_q <= NBITS_RST;
    end else if (ce) begin
      if (sel_fall) begin
        res_q <= CODE_MID;
        nbits_q <= NBITS_RST;
      end else if (active_q && !sel_s2_q && bit_fall && fwd_bit) begin
        res_q[bit_idx] <= resolve_phase_q[bit_idx];
        nbits_q <= nbits_q + 4'h1;
      end
    end
  end

  // report the frame result when select rises
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      result <= CODE_MID;
      result_bits <= NBITS_RST;
      result_stb <= 1'b0;
    end else if (ce) begin
      result_stb <= 1'b0;
      if (sel_rise && active_q) begin
        result <= res_q;
        result_bits <= nbits_q;
        result_stb <= 1'b1;
      end
    end
  end

  // first frame of sixteen or more clocks after power-on primes the track and hold
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      primed <= 1'b0;
    end else if (ce) begin
      if (sel_rise && active_q && edge_cnt_q >= FRAME_CLKS) begin
        primed <= 1'b1;
      end
    end
  end

  // power mode follows the select level three mclk cycles after the pin, once power-on ends
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dynamic_mode <= 1'b0;
    end else if (ce) begin
      dynamic_mode <= por_done & ~sel_s2_q;
    end
  end

  // pins driven from flip-flops
  assign link.sdo = sdo_q;
  assign link.sdo_oe_n = sdo_oe_n_q;

endmodule // sar_dev

// ==== logic/sar_host.sv ====
// host end: drives select and bit clock, reads one word per frame
// assumes a user sink with valid/ready on the same mclk
`timescale 1ns/1ps
module sar_host #(
  parameter int unsigned POR_CYCLES = sar_pkg::POR_CYC
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // serial link
  sar_link_if.host link,
  // conversion request
  input wire logic resolve_phase_req,
  output logic start_ready,
  output logic busy,
  output logic primed,
  // result stream
  output sar_pkg::sar_code_t word_data,
  output logic word_valid,
  input wire logic word_ready
);
  import sar_pkg::*;

  sar_hstate_t state_q;
  logic [POR_W-1:0] por_cnt_q;
  logic [DIV_W-1:0] div_q;
  logic [GAP_W-1:0] gap_q;
  logic [EDGE_W-1:0] rise_cnt_q;
  logic [EDGE_W-1:0] fall_cnt_q;
  logic dummy_q;
  logic sel_q;
  logic bclk_q;
  logic sdi_s1_q;
  logic sdi_s2_q;
  sar_code_t shift_q;
  sar_code_t slot1_q;
  logic v1_q;
  logic tick;
  logic frame_end;
  logic push;
  logic pop;

  assign tick = (div_q == DIV_W'(BIT_HALF_CYC - 1));
  // frame ends half a bit clock after the sixteenth fall, clock low,
  // so the converter end counts that fall before select rises
  assign frame_end = (state_q == SAR_HS_FRAME) && tick && !bclk_q &&
    (fall_cnt_q == FRAME_CLKS);
  assign push = frame_end && !dummy_q;
  assign pop = word_valid && word_ready;

  // data line synchroniser
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sdi_s1_q <= 1'b1;
      sdi_s2_q <= 1'b1;
    end else if (ce) begin
      sdi_s1_q <= link.sdo_line;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  // sequencer: power-on wait, dummy frame, then frames on request
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= SAR_HS_POR;
      por_cnt_q <= '0;
      gap_q <= '0;
      dummy_q <= 1'b1;
      sel_q <= 1'b1;
    end else if (ce) begin
      case (state_q)
        SAR_HS_POR: begin
          if (por_cnt_q == POR_W'(POR_CYCLES - 1)) begin
            state_q <= SAR_HS_FRAME;
            sel_q <= 1'b0;
          end else begin
            por_cnt_q <= por_cnt_q + POR_W'(1);
          end
        end
        SAR_HS_FRAME: begin
          if (frame_end) begin
            // sixteen clocks given; release select to float the line
            state_q <= SAR_HS_GAP;
            sel_q <= 1'b1;
            dummy_q <= 1'b0;
            gap_q <= '0;
          end
        end
        SAR_HS_GAP: begin
          if (gap_q == GAP_W'(ACQ_GAP_CYC - 1)) begin
            state_q <= SAR_HS_IDLE;
          end else begin
            gap_q <= gap_q + GAP_W'(1);
          end
        end
        SAR_HS_IDLE: begin
          // select idles high between frames
          if (resolve_phase_req && !v1_q) begin
            state_q <= SAR_HS_FRAME;
            sel_q <= 1'b0;
          end
        end
        default: begin
          state_q <= SAR_HS_POR;
          sel_q <= 1'b1;
        end
      endcase
    end
  end

  // bit clock divider; low at select fall, within the rate limit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= '0;
      bclk_q <= 1'b0;
      rise_cnt_q <= '0;
      fall_cnt_q <= '0;
    end else if (ce) begin
      if (state_q != SAR_HS_FRAME || frame_end) begin
        div_q <= '0;
        bclk_q <= 1'b0;
        rise_cnt_q <= '0;
        fall_cnt_q <= '0;
      end else if (tick) begin
        div_q <= '0;
        bclk_q <= ~bclk_q;
        if (bclk_q) begin
          fall_cnt_q <= fall_cnt_q + EDGE_W'(1);
        end else begin
          rise_cnt_q <= rise_cnt_q + EDGE_W'(1);
        end
      end else begin
        div_q <= div_q + DIV_W'(1);
      end
    end
  end

  // capture on rising edges, skipping the null bit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q <= CODE_MID;
    end else if (ce) begin
      if (state_q == SAR_HS_FRAME && tick && !bclk_q &&
          rise_cnt_q >= FIRST_CAP_RISE - EDGE_W'(1) &&
          rise_cnt_q <= LAST_CAP_RISE - EDGE_W'(1)) begin
        shift_q <= {shift_q[CODE_W-2:0], sdi_s2_q};
      end
    end
  end

  // two-entry buffer: head in word_data, second in slot1
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_data <= CODE_MID;
      word_valid <= 1'b0;
      slot1_q <= CODE_MID;
      v1_q <= 1'b0;
    end else if (ce) begin
      if (push && !pop) begin
        if (!word_valid) begin
          word_data <= shift_q;
          word_valid <= 1'b1;
        end else begin
          slot1_q <= shift_q;
          v1_q <= 1'b1;
        end
      end else if (pop && !push) begin
        word_data <= slot1_q;
        word_valid <= v1_q;
        v1_q <= 1'b0;
      end else if (pop && push) begin
        if (v1_q) begin
          word_data <= slot1_q;
          slot1_q <= shift_q;
        end else begin
          word_data <= shift_q;
        end
      end
    end
  end

  // status flags
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      start_ready <= 1'b0;
      busy <= 1'b1;
      primed <= 1'b0;
    end else if (ce) begin
      start_ready <= (state_q == SAR_HS_IDLE) && !v1_q &&
        !(resolve_phase_req && !v1_q) && !(push && word_valid && !pop);
      busy <= (state_q != SAR_HS_IDLE) || (resolve_phase_req && !v1_q);
      primed <= primed | (frame_end && dummy_q);
    end
  end

  assign link.select_shutdown_n = sel_q;
  assign link.conversion_bit_clock = bclk_q;

endmodule // sar_host

// ==== logic/sar_link_if.sv ====
// link between the converter end and the host end
// assumes the testbench joins both ends here; data line is pulled high
`timescale 1ns/1ps
interface sar_link_if (
  input wire logic mclk
);
  logic select_shutdown_n;
  logic conversion_bit_clock;
  logic sdo;
  logic sdo_oe_n;
  logic sdo_line;

  // released data line reads as the pull-up level
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

  modport dev (
    input select_shutdown_n,
    input conversion_bit_clock,
    output sdo,
    output sdo_oe_n
  );

  modport host (
    output select_shutdown_n,
    output conversion_bit_clock,
    input sdo_line
  );
endinterface

// ==== logic/sar_pkg.sv ====
// shared constants and types for the serial converter link
// assumes both ends run on one 40 MHz clock, mclk
package sar_pkg;

  // result word
  localparam int CODE_W = 12;
  typedef logic [CODE_W-1:0] sar_code_t;

  // two's complement landmarks of the result
  localparam sar_code_t CODE_NEG_FS = 12'h800;
  localparam sar_code_t CODE_MID = 12'h000;
  localparam sar_code_t CODE_POS_FS = 12'h7ff;

  // system clock and bit clock rates
  localparam int MCLK_KHZ = 40000;
  localparam int CLK_NS = 25;
  localparam int BIT_CLK_MAX_KHZ = 3200;
  // least half period of the bit clock, rounded up to whole mclk cycles
  localparam int BIT_HALF_CYC =
    (MCLK_KHZ + 2 * BIT_CLK_MAX_KHZ - 1) / (2 * BIT_CLK_MAX_KHZ);
  localparam int DIV_W = 4;

  // power-on reset time and its count of mclk cycles
  localparam int POR_NS = 2500000;
  localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int POR_W = 17;

  // idle time with select high between frames: two bit clock periods
  localparam int ACQ_GAP_CYC = 4 * BIT_HALF_CYC;
  localparam int GAP_W = 5;

  // frame sequencing, counted in bit clock falling edges
  localparam int EDGE_W = 5;
  localparam logic [EDGE_W-1:0] FRAME_CLKS = 5'h10;
  localparam logic [EDGE_W-1:0] NULL_EDGE = 5'h01;
  localparam logic [EDGE_W-1:0] MSB_EDGE = 5'h02;
  localparam logic [EDGE_W-1:0] LSB_EDGE = 5'h0d;
  localparam logic [EDGE_W-1:0] REV_END_EDGE = 5'h18;
  localparam logic [EDGE_W-1:0] FLOAT_EDGE = 5'h19;
  localparam logic [EDGE_W-1:0] SHORT_LIMIT = 5'h0c;
  // host capture window, counted in rising edges
  localparam logic [EDGE_W-1:0] FIRST_CAP_RISE = 5'h03;
  localparam logic [EDGE_W-1:0] LAST_CAP_RISE = 5'h0e;

  // reset values
  localparam logic [3:0] NBITS_RST = 4'h0;

  // host sequencer states
  typedef enum logic [1:0] {
    SAR_HS_POR,
    SAR_HS_FRAME,
    SAR_HS_GAP,
    SAR_HS_IDLE
  } sar_hstate_t;

endpackage

// ==== testbench/sar_link_checker.sv ====
// wire checks on the link joining host end and converter end
// assumes one mclk domain; host end drives select and bit clock
`timescale 1ns/1ps
module sar_link_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // link signals
  input wire logic select_shutdown_n,
  input wire logic conversion_bit_clock,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic sdo_line
);
  import sar_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [4:0] falls_q;
  logic [4:0] half_q;
  logic [5:0] high_q;

  // bit clock falls within the current frame
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) falls_q <= 5'h00;
    else if (select_shutdown_n) falls_q <= 5'h00;
    else if ($fell(conversion_bit_clock)) falls_q <= falls_q + 5'h01;
  end

  // cycles since the bit clock last moved, saturating
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) half_q <= 5'h1f;
    else if ($changed(conversion_bit_clock)) half_q <= 5'h00;
    else if (half_q != 5'h1f) half_q <= half_q + 5'h01;
  end

  // cycles with select high; starts full so the first frame passes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) high_q <= 6'h3f;
    else if (!select_shutdown_n) high_q <= 6'h00;
    else if (high_q != 6'h3f) high_q <= high_q + 6'h01;
  end

  chk_release_float: assert property (
    select_shutdown_n [*5] |-> sdo_oe_n)
    else $error("data line driven while deselected");
  chk_float_to_null: assert property (
    $fell(select_shutdown_n) |-> sdo_oe_n [*8])
    else $error("data line driven before null bit");
  chk_null_first: assert property (
    $fell(sdo_oe_n) |-> !sdo && !sdo_line)
    else $error("first driven bit not null");
  chk_change_on_fall: assert property (
    conversion_bit_clock |-> $stable(sdo))
    else $error("data moved while bit clock high");
  chk_enable_window: assert property (
    $fell(select_shutdown_n) ##1 !select_shutdown_n [*8]
    |-> ##[6:12] $fell(sdo_oe_n))
    else $error("null bit not driven on first fall");
  chk_frame_length: assert property (
    $rose(select_shutdown_n) |-> falls_q == FRAME_CLKS)
    else $error("frame not sixteen clocks");
  chk_bit_half_period: assert property (
    $changed(conversion_bit_clock) |-> half_q >= BIT_HALF_CYC - 1)
    else $error("bit clock too fast");
  chk_acq_gap: assert property (
    $fell(select_shutdown_n) |-> high_q >= ACQ_GAP_CYC - 1)
    else $error("acquisition gap too short");
endmodule // sar_link_checker

// ==== testbench/testbench.sv ====
// bench joining host end and converter end, plus a lone converter end
// assumes package and interface compiled first; lone end is bench driven
`timescale 1ns/1ps
module testbench;
  import sar_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic resolve_phase_req = 1'b0;
  logic word_ready = 1'b0;
  logic stall = 1'b0;
  sar_code_t code_a = 12'h000;
  sar_code_t code_b = 12'h000;
  sar_code_t word_data, d_res, b_res, b_res_q;
  logic start_ready, busy, h_prim, word_valid, por, d_prim, dyn, stb;
  logic b_por, b_prim, b_dyn, b_stb;
  logic [3:0] d_bits, b_bits, b_bits_q;
  logic [31:0] seen;
  sar_code_t word_q[$];
  sar_code_t dev_q[$];
  int failures = 0;
  int check_count = 0;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  sar_link_if link_a (.mclk(mclk));
  sar_link_if link_b (.mclk(mclk));
  sar_dev #(.POR_CYCLES(20)) sar_dev_i (.mclk(mclk), .sys_rst(sys_rst),
    .ce(ce), .link(link_a.dev), .sample_code(code_a), .por_done(por),
    .primed(d_prim), .dynamic_mode(dyn), .result(d_res),
    .result_bits(d_bits), .result_stb(stb));
  sar_host #(.POR_CYCLES(20)) sar_host_i (.mclk(mclk), .sys_rst(sys_rst),
    .ce(ce), .link(link_a.host), .resolve_phase_req(resolve_phase_req),
    .start_ready(start_ready), .busy(busy), .primed(h_prim),
    .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready));
  sar_dev #(.POR_CYCLES(20)) sar_dev_b_i (.mclk(mclk), .sys_rst(sys_rst),
    .ce(ce), .link(link_b.dev), .sample_code(code_b), .por_done(b_por),
    .primed(b_prim), .dynamic_mode(b_dyn), .result(b_res),
    .result_bits(b_bits), .result_stb(b_stb));
  sar_link_checker sar_link_checker_i (.mclk(mclk), .sys_rst(sys_rst),
    .select_shutdown_n(link_a.select_shutdown_n),
    .conversion_bit_clock(link_a.conversion_bit_clock),
    .sdo(link_a.sdo), .sdo_oe_n(link_a.sdo_oe_n),
    .sdo_line(link_a.sdo_line));

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // expected line at rises: float, null, msb first, reversed, float
  function automatic logic [31:0] stream_of(input sar_code_t c);
    logic [31:0] s;
    s = {4'h0, 1'b1, 1'b0, c, 14'h0000};
    for (int i = 1; i < 12; i++) s[14 - i] = c[i];
    s[2:0] = 3'b111;
    return s;
  endfunction

  // one request through the host, noting the expected word
  task automatic convert(input sar_code_t c);
    int n;
    n = 0;
    while (start_ready !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    check("start ready", 1, start_ready);
    code_a = c;
    word_q.push_back(c);
    dev_q.push_back(c);
    resolve_phase_req = 1'b1;
    @(negedge mclk);
    resolve_phase_req = 1'b0;
    repeat (40) @(negedge mclk);
    check("dynamic", 1, dyn);
    check("busy", 1, busy);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (word_q.size() != 0 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    check("words left", 0, word_q.size());
  endtask

  // bench as host on the lone link; select left low at the end
  task automatic frame_b(input int falls);
    seen = 32'h0;
    link_b.select_shutdown_n = 1'b0;
    for (int i = 0; i < falls; i++) begin
      repeat (7) @(negedge mclk);
      link_b.conversion_bit_clock = 1'b1;
      seen = {seen[30:0], link_b.sdo_line};
      repeat (7) @(negedge mclk);
      link_b.conversion_bit_clock = 1'b0;
    end
    repeat (7) @(negedge mclk);
  endtask

  // random back-pressure on the result stream
  always @(negedge mclk) word_ready = !stall && ($urandom % 4 != 0);

  // oldest note against each accepted word
  always @(posedge mclk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      if (word_q.size() == 0) check("extra word", ~word_data, word_data);
      else check("word", word_q.pop_front(), word_data);
    end
  end

  // converter end result against the noted code
  always @(posedge mclk) begin
    if (stb === 1'b1) begin
      check("result bits", 12, d_bits);
      if (dev_q.size() != 0) check("result", dev_q.pop_front(), d_res);
    end
    if (b_stb === 1'b1) begin
      b_res_q <= b_res;
      b_bits_q <= b_bits;
    end
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("FAIL watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial begin
    void'($urandom(6));
    link_b.select_shutdown_n = 1'b1;
    link_b.conversion_bit_clock = 1'b0;
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    check("por early", 0, por);
    dev_q.push_back(12'h000);
    convert(CODE_NEG_FS);
    check("primed", 3, {h_prim, d_prim});
    convert(CODE_MID);
    convert(CODE_POS_FS);
    for (int i = 0; i < 3; i++) convert(12'($urandom));
    drain();
    stall = 1'b1;
    convert(12'($urandom));
    convert(12'($urandom));
    repeat (600) @(negedge mclk);
    check("full refuses", 0, start_ready);
    stall = 1'b0;
    drain();
    check("idle static", 0, dyn);
    check("idle busy", 0, busy);
    // clock enable low: a request must not be taken
    ce = 1'b0;
    resolve_phase_req = 1'b1;
    repeat (10) @(negedge mclk);
    check("frozen busy", 0, busy);
    check("frozen ready", 1, start_ready);
    resolve_phase_req = 1'b0;
    ce = 1'b1;
    code_b = 12'h9c6;
    check("lone por", 1, b_por);
    frame_b(28);
    check("stream", stream_of(code_b), seen[27:0]);
    check("float after", 1, link_b.sdo_oe_n);
    check("still dynamic", 1, b_dyn);
    link_b.select_shutdown_n = 1'b1;
    repeat (40) @(negedge mclk);
    check("full result", code_b, b_res_q);
    check("full bits", 12, b_bits_q);
    check("lone primed", 1, b_prim);
    code_b = 12'h3b5;
    frame_b(5);
    check("short line", {1'b1, 1'b0, code_b[11:9]}, seen[4:0]);
    check("short driving", 0, link_b.sdo_oe_n);
    link_b.select_shutdown_n = 1'b1;
    repeat (8) @(negedge mclk);
    check("abort float", 1, link_b.sdo_oe_n);
    check("early static", 0, b_dyn);
    check("short result", {code_b[11:8], 8'h00}, b_res_q);
    check("short bits", 4, b_bits_q);
    repeat (40) @(negedge mclk);
    tally_and_finish();
  end
endmodule // testbench
